// ### include/btel_pkg.sv
// Constants and types for the bus target error logger.
// Assumes one system bus clock and a plain strobe register port.
package btel_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_LOG       = 8'h00;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h08;

    // Error log field positions
    localparam int MULTI_BIT = 31;
    localparam int CODE_HI   = 27;
    localparam int CODE_LO   = 24;
    localparam int ID_HI     = 15;
    localparam int ID_LO     = 8;
    localparam int REG_HI    = 7;
    localparam int REG_LO    = 4;
    localparam int CMD_HI    = 2;
    localparam int CMD_LO    = 0;

    // Error type encodings
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_PERM = 4'h3;

    // Requester identifiers
    localparam logic [7:0] ID_RESERVED = 8'h00;
    localparam logic [7:0] ID_CPU_LO   = 8'h01;
    localparam logic [7:0] ID_CPU_HI   = 8'h02;
    localparam logic [7:0] ID_DMARD_LO = 8'h03;
    localparam logic [7:0] ID_DMARD_HI = 8'h04;
    localparam logic [7:0] ID_DMAWR_LO = 8'h05;
    localparam logic [7:0] ID_DMAWR_HI = 8'h06;
    localparam logic [7:0] ID_USB      = 8'h07;
    localparam logic [7:0] ID_ETH_RD   = 8'h08;
    localparam logic [7:0] ID_ETH_WR   = 8'h09;
    localparam logic [7:0] ID_OTH_MIN  = 8'h0a;
    localparam logic [7:0] ID_OTH_MAX  = 8'h0e;

    // Interrupt status and mask layout
    localparam int IRQ_W      = 2;
    localparam int IRQ_LOGGED = 0;
    localparam int IRQ_MULTI  = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    typedef enum logic [2:0] {
        SRC_CPU,
        SRC_DMA_RD,
        SRC_DMA_WR,
        SRC_USB,
        SRC_ETH_RD,
        SRC_ETH_WR,
        SRC_OTHER
    } btel_src_t;

endpackage

// ### rtl/btel_top.sv
// Bus target error logger: records the first permission violation at
// one target, flags repeats, and raises a maskable interrupt.
// Assumes violation inputs are synchronous one-cycle pulses from the
// target's permission checker, and a single-cycle strobe register port.
//
// Notes on behaviour
// RULE1: Multi flag bit 31 sets when a violation arrives while one is already logged.
// RULE2: Writing one to bit 31 clears multi; writing zero leaves it.
// RULE3: Error type bits 27-24 show 0011 on violation, 0000 when none logged.
// RULE4: Writing ones to the error type field returns it to no-error.
// RULE5: Bits 15-8 capture the requester identifier of the logged violation, read-only.
// RULE6: Identifier encodes processor, DMA read/write, USB, Ethernet, other masters; else reserved.
// RULE7: Bits 30-28 and 23-16 always read zero; writes there do nothing.
// RULE8: Region bits 7-4 and command bits 2-0 captured on violation; reset zero.
`timescale 1ns/1ps
`default_nettype none

module btel_top (
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    input  wire logic [7:0]              i_addr,
    input  wire logic [31:0]             i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output var  logic [31:0]             o_rdata,
    input  wire logic                    i_viol,
    input  wire btel_pkg::btel_src_t     i_viol_src,
    input  wire logic [7:0]              i_viol_other_id,
    input  wire logic                    i_processor_priority_select,
    input  wire logic                    i_dma_priority_select,
    input  wire logic [3:0]              i_viol_region,
    input  wire logic [2:0]              i_viol_cmd,
    output var  logic                    o_error_logged,
    output var  logic                    o_irq
);

    logic [3:0]                err_code;
    logic                      multi;
    logic [7:0]                requester_identifier;
    logic [3:0]                region;
    logic [2:0]                cmd;
    logic [btel_pkg::IRQ_W-1:0] irq_stat;
    logic [btel_pkg::IRQ_W-1:0] irq_mask;
    logic [btel_pkg::IRQ_W-1:0] next_irq_stat;
    logic [btel_pkg::IRQ_W-1:0] next_irq_mask;
    logic [btel_pkg::IRQ_W-1:0] irq_events;
    logic [31:0]               log_word;
    logic [7:0]                viol_id;
    logic                      logged;
    logic                      wr_log;
    logic                      clr_multi;
    logic                      clr_code;
    logic                      first_viol;
    logic                      repeat_viol;
    logic                      rd_stat;

    // Identifier of the offending requester, by kind and priority
    function automatic logic [7:0] encode_id(
        input btel_pkg::btel_src_t src,
        input logic                cpu_pri,
        input logic                dma_pri,
        input logic [7:0]          other
    );
        logic [7:0] id;
        id = btel_pkg::ID_RESERVED;
        case (src)
            btel_pkg::SRC_CPU: begin
                id = cpu_pri ? btel_pkg::ID_CPU_HI : btel_pkg::ID_CPU_LO; // [RULE6]
            end
            btel_pkg::SRC_DMA_RD: begin
                id = dma_pri ? btel_pkg::ID_DMARD_HI : btel_pkg::ID_DMARD_LO; // [RULE6]
            end
            btel_pkg::SRC_DMA_WR: begin
                id = dma_pri ? btel_pkg::ID_DMAWR_HI : btel_pkg::ID_DMAWR_LO; // [RULE6]
            end
            btel_pkg::SRC_USB: begin
                id = btel_pkg::ID_USB; // [RULE6]
            end
            btel_pkg::SRC_ETH_RD: begin
                id = btel_pkg::ID_ETH_RD; // [RULE6]
            end
            btel_pkg::SRC_ETH_WR: begin
                id = btel_pkg::ID_ETH_WR; // [RULE6]
            end
            btel_pkg::SRC_OTHER: begin
                // Out-of-range master numbers would alias a named one, so log reserved
                if (other >= btel_pkg::ID_OTH_MIN && other <= btel_pkg::ID_OTH_MAX) begin
                    id = other; // [RULE6]
                end
            end
            default: begin
                id = btel_pkg::ID_RESERVED;
            end
        endcase
        return id;
    endfunction

    assign viol_id     = encode_id(i_viol_src, i_processor_priority_select,
                                   i_dma_priority_select, i_viol_other_id);
    assign logged      = (err_code != btel_pkg::CODE_NONE);
    assign first_viol  = i_viol && !logged;
    assign repeat_viol = i_viol && logged;
    assign wr_log      = i_wr && (i_addr == btel_pkg::OFS_LOG);
    assign clr_multi   = wr_log && i_wdata[btel_pkg::MULTI_BIT];
    assign clr_code    = wr_log && (|i_wdata[btel_pkg::CODE_HI:btel_pkg::CODE_LO]);
    assign rd_stat     = i_rd && (i_addr == btel_pkg::OFS_IRQ_STAT);

    // A violation landing on the clearing write wins, so no error is lost
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            err_code <= btel_pkg::CODE_NONE;
        end else if (i_viol) begin
            err_code <= btel_pkg::CODE_PERM; // [RULE3]
        end else if (clr_code) begin
            err_code <= btel_pkg::CODE_NONE; // [RULE4]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            multi <= 1'b0;
        end else if (repeat_viol) begin
            multi <= 1'b1; // [RULE1]
        end else if (clr_multi) begin
            multi <= 1'b0; // [RULE2]
        end
    end

    // Details describe the first violation only; repeats just raise multi
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            requester_identifier <= btel_pkg::ID_RESERVED;
            region               <= 4'h0;
            cmd                  <= 3'h0;
        end else if (first_viol) begin
            requester_identifier <= viol_id;       // [RULE5]
            region               <= i_viol_region; // [RULE8]
            cmd                  <= i_viol_cmd;    // [RULE8]
        end
    end

    // Unimplemented bits are tied low in the read word
    always_comb begin
        log_word = 32'h0; // [RULE7]
        log_word[btel_pkg::MULTI_BIT]                 = multi;
        log_word[btel_pkg::CODE_HI:btel_pkg::CODE_LO] = err_code;
        log_word[btel_pkg::ID_HI:btel_pkg::ID_LO]     = requester_identifier;
        log_word[btel_pkg::REG_HI:btel_pkg::REG_LO]   = region;
        log_word[btel_pkg::CMD_HI:btel_pkg::CMD_LO]   = cmd;
    end

    // Interrupt events: set beats the read-clear in the same cycle
    always_comb begin
        irq_events                       = btel_pkg::IRQ_RESET;
        irq_events[btel_pkg::IRQ_LOGGED] = first_viol;
        irq_events[btel_pkg::IRQ_MULTI]  = repeat_viol;
        next_irq_stat = (rd_stat ? btel_pkg::IRQ_RESET : irq_stat) | irq_events;
        next_irq_mask = irq_mask;
        if (i_wr && (i_addr == btel_pkg::OFS_IRQ_MASK)) begin
            next_irq_mask = i_wdata[btel_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            irq_stat <= btel_pkg::IRQ_RESET;
        end else begin
            irq_stat <= next_irq_stat;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            irq_mask <= btel_pkg::IRQ_RESET;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    // Built from next values so the pin tracks status with no extra lag
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(next_irq_stat & next_irq_mask);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_error_logged <= 1'b0;
        end else begin
            o_error_logged <= i_viol || (logged && !clr_code);
        end
    end

    // Read data stand for one cycle only; status shows its value before clearing
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_rdata <= 32'h0;
        end else if (i_rd) begin
            case (i_addr)
                btel_pkg::OFS_LOG: begin
                    o_rdata <= log_word; // [RULE7]
                end
                btel_pkg::OFS_IRQ_STAT: begin
                    o_rdata <= {30'h0, irq_stat};
                end
                btel_pkg::OFS_IRQ_MASK: begin
                    o_rdata <= {30'h0, irq_mask};
                end
                default: begin
                    o_rdata <= 32'h0;
                end
            endcase
        end else begin
            o_rdata <= 32'h0;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_first_hit;
        i_viol && !logged;
    endsequence

    sequence s_log_read;
        i_rd && !i_wr && (i_addr == btel_pkg::OFS_LOG);
    endsequence

    a_multi_sets: assert property ( // [RULE1]
        i_viol && logged |=> multi
    ) else $error("multi flag not set on repeated violation");

    a_multi_stays_clear: assert property ( // [RULE1]
        !multi && !(i_viol && logged) |=> !multi
    ) else $error("multi flag set without a repeated violation");

    a_multi_clears: assert property ( // [RULE2]
        wr_log && i_wdata[btel_pkg::MULTI_BIT] && !(i_viol && logged) |=> !multi
    ) else $error("multi flag not cleared by write of one");

    a_multi_zero_write: assert property ( // [RULE2]
        multi && wr_log && !i_wdata[btel_pkg::MULTI_BIT] |=> multi
    ) else $error("write of zero changed multi flag");

    a_code_legal: assert property ( // [RULE3]
        err_code == btel_pkg::CODE_NONE || err_code == btel_pkg::CODE_PERM
    ) else $error("error type holds a reserved encoding");

    a_code_on_viol: assert property ( // [RULE3]
        i_viol |=> err_code == btel_pkg::CODE_PERM && o_error_logged
    ) else $error("violation not logged as permission error");

    a_code_clears: assert property ( // [RULE4]
        clr_code && !i_viol |=> err_code == btel_pkg::CODE_NONE
    ) else $error("error type not cleared by write of ones");

    a_id_capture: assert property ( // [RULE5]
        s_first_hit |=> requester_identifier == $past(viol_id)
    ) else $error("requester identifier not captured");

    a_id_holds: assert property ( // [RULE5]
        logged |=> requester_identifier == $past(requester_identifier)
    ) else $error("requester identifier changed while logged");

    a_id_encoding: assert property ( // [RULE6]
        s_first_hit ##0 (i_viol_src == btel_pkg::SRC_USB)
            |=> requester_identifier == btel_pkg::ID_USB
    ) else $error("USB identifier wrongly encoded");

    a_reserved_zero: assert property ( // [RULE7]
        s_log_read |=> o_rdata[30:28] == 3'h0 && o_rdata[23:16] == 8'h00
            && o_rdata[3] == 1'b0
    ) else $error("unimplemented log bits read nonzero");

    a_detail_capture: assert property ( // [RULE8]
        s_first_hit |=> region == $past(i_viol_region) && cmd == $past(i_viol_cmd)
    ) else $error("region or command not captured");

    a_viol_readback: assert property ( // [RULE3]
        i_viol ##1 s_log_read |=>
            o_rdata[btel_pkg::CODE_HI:btel_pkg::CODE_LO] == btel_pkg::CODE_PERM
    ) else $error("logged error type not visible on read");

    a_irq_raise: assert property (
        s_first_hit ##0 irq_mask[btel_pkg::IRQ_LOGGED] && !i_wr |=> o_irq
    ) else $error("interrupt not raised for unmasked event");

    a_multi_keeps_code: assert property ( // [RULE2]
        clr_multi && !clr_code && !i_viol |=> err_code == $past(err_code)
    ) else $error("clearing multi flag disturbed error type");

    a_code_holds: assert property ( // [RULE4]
        !clr_code && !i_viol |=> err_code == $past(err_code)
    ) else $error("error type changed without violation or clear");

    a_detail_holds: assert property ( // [RULE8]
        logged |=> region == $past(region) && cmd == $past(cmd)
    ) else $error("region or command changed while logged");

    a_id_reserved: assert property ( // [RULE6]
        s_first_hit ##0 (i_viol_src == btel_pkg::SRC_OTHER)
            ##0 (i_viol_other_id > btel_pkg::ID_OTH_MAX)
            |=> requester_identifier == btel_pkg::ID_RESERVED
    ) else $error("out-of-range master not logged as reserved");

    a_cpu_encoding: assert property ( // [RULE6]
        s_first_hit ##0 (i_viol_src == btel_pkg::SRC_CPU) |=> requester_identifier
            == ($past(i_processor_priority_select) ? btel_pkg::ID_CPU_HI : btel_pkg::ID_CPU_LO)
    ) else $error("processor identifier wrongly encoded");

    a_dma_wr_encoding: assert property ( // [RULE6]
        s_first_hit ##0 (i_viol_src == btel_pkg::SRC_DMA_WR) |=> requester_identifier
            == ($past(i_dma_priority_select) ? btel_pkg::ID_DMAWR_HI : btel_pkg::ID_DMAWR_LO)
    ) else $error("DMA write identifier wrongly encoded");

    a_stat_logged: assert property (
        s_first_hit |=> irq_stat[btel_pkg::IRQ_LOGGED]
    ) else $error("status not set for first violation");

    a_stat_multi: assert property (
        i_viol && logged |=> irq_stat[btel_pkg::IRQ_MULTI]
    ) else $error("status not set for repeated violation");

    a_stat_read_clear: assert property (
        rd_stat && !i_viol |=> irq_stat == btel_pkg::IRQ_RESET
    ) else $error("status not cleared by read");

    a_irq_masked: assert property (
        !i_wr && irq_mask == btel_pkg::IRQ_RESET |=> !o_irq
    ) else $error("interrupt raised while fully masked");

    a_logged_drops: assert property ( // [RULE4]
        clr_code && !i_viol |=> !o_error_logged
    ) else $error("logged output stayed high after clear");

    a_rdata_idle: assert property (
        !i_rd |=> o_rdata == 32'h0
    ) else $error("read data nonzero without a read");

endmodule

`default_nettype wire

// ### verification/btel_initiator_model.sv
// Behavioural system bus initiator that commits permission violations.
// Assumes the bench calls fire() from one thread, one event per call.
`timescale 1ns/1ps
`default_nettype none
module btel_initiator_model (
    input  wire logic                i_clk,
    output var  logic                o_viol,
    output var  btel_pkg::btel_src_t o_src,
    output var  logic [7:0]          o_other_id,
    output var  logic                o_cpu_pri,
    output var  logic                o_dma_pri,
    output var  logic [3:0]          o_region,
    output var  logic [2:0]          o_cmd
);
    initial begin
        o_viol     = 1'b0;
        o_src      = btel_pkg::SRC_CPU;
        o_other_id = 8'h00;
        o_cpu_pri  = 1'b0;
        o_dma_pri  = 1'b0;
        o_region   = 4'h0;
        o_cmd      = 3'h0;
    end

    // Waits gap edges plus one before raising the violation, so the model can be prompt or slow
    task automatic fire(input btel_pkg::btel_src_t s, input logic [7:0] oid, input logic cp,
                        input logic dp, input logic [3:0] rg, input logic [2:0] cm, input int gap);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_viol     <= 1'b1;
        o_src      <= s;
        o_other_id <= oid;
        o_cpu_pri  <= cp;
        o_dma_pri  <= dp;
        o_region   <= rg;
        o_cmd      <= cm;
        @(posedge i_clk);
        // Source, other id, region and command are scrambled once the event is taken; the priority selects keep their values
        o_viol     <= 1'b0;
        o_src      <= btel_pkg::btel_src_t'(~s);
        o_other_id <= ~oid;
        o_region   <= ~rg;
        o_cmd      <= ~cm;
    endtask
endmodule
`default_nettype wire

// ### verification/bus_target_error_log_test.sv
// Self-checking bench for the bus target error logger.
// Assumes the initiator model drives the violation port and the bench owns the register port.
`timescale 1ns/1ps
`default_nettype none
module bus_target_error_log_test;
    logic                i_clk;
    logic                i_nrst;
    logic [7:0]          i_addr;
    logic [31:0]         i_wdata;
    logic                i_wr;
    logic                i_rd;
    logic [31:0]         o_rdata;
    logic                viol;
    btel_pkg::btel_src_t src;
    logic [7:0]          oid;
    logic                cpu_pri;
    logic                dma_pri;
    logic [3:0]          region;
    logic [2:0]          cmd;
    logic                o_error_logged;
    logic                o_irq;
    int                  fails;
    int                  check_count;
    int                  cycles;
    logic [31:0]         seed;
    logic [31:0]         v;
    logic [31:0]         exp_log;
    logic [7:0]          r_oid;
    logic [3:0]          r_reg;
    logic [2:0]          r_cmd;

    btel_top u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_viol(viol), .i_viol_src(src),
        .i_viol_other_id(oid), .i_processor_priority_select(cpu_pri),
        .i_dma_priority_select(dma_pri), .i_viol_region(region), .i_viol_cmd(cmd),
        .o_error_logged(o_error_logged), .o_irq(o_irq));
    btel_initiator_model u_init (.i_clk(i_clk), .o_viol(viol), .o_src(src), .o_other_id(oid),
        .o_cpu_pri(cpu_pri), .o_dma_pri(dma_pri), .o_region(region), .o_cmd(cmd));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    function automatic logic [7:0] exp_id(btel_pkg::btel_src_t s, logic cp, logic dp,
                                          logic [7:0] o);
        case (s)
            btel_pkg::SRC_CPU:    return cp ? 8'h02 : 8'h01;
            btel_pkg::SRC_DMA_RD: return dp ? 8'h04 : 8'h03;
            btel_pkg::SRC_DMA_WR: return dp ? 8'h06 : 8'h05;
            btel_pkg::SRC_USB:    return 8'h07;
            btel_pkg::SRC_ETH_RD: return 8'h08;
            btel_pkg::SRC_ETH_WR: return 8'h09;
            default:              return (o >= 8'h0a && o <= 8'h0e) ? o : 8'h00;
        endcase
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask

    // Read data are only valid in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        {i_addr, i_wdata, i_wr, i_rd, fails, check_count, cycles} = '0;
        seed   = 32'h6dd59bbe;
        i_nrst = 1'b0;
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            rd(8'(a), v);
            chk("reset value", v, 32'h0);
        end
        $display("test reset done");
        wr(btel_pkg::OFS_IRQ_MASK, 32'hffff_ffff);
        for (int k = 0; k < 14; k++) begin
            r_oid = 8'($random(seed) & 15);
            r_reg = 4'($random(seed));
            r_cmd = 3'($random(seed));
            u_init.fire(btel_pkg::btel_src_t'(k % 7), r_oid, k >= 7, k < 7,
                        r_reg, r_cmd, k % 3);
            exp_log = {8'h03, 8'h00, exp_id(btel_pkg::btel_src_t'(k % 7), k >= 7, k < 7,
                       r_oid), r_reg, 1'b0, r_cmd};
            #1 chk("logged flag", {31'h0, o_error_logged}, 32'h1);
            chk("irq raised", {31'h0, o_irq}, 32'h1);
            rd(btel_pkg::OFS_LOG, v);
            chk("first log", v, exp_log);
            rd(btel_pkg::OFS_IRQ_STAT, v);
            chk("status", v, 32'h1);
            wr(btel_pkg::OFS_LOG, {8'h70 | 8'(k + 1), 24'hff_ffff});
            rd(btel_pkg::OFS_LOG, v);
            chk("type cleared", v, exp_log & 32'h0000_fff7);
            chk("logged low", {31'h0, o_error_logged}, 32'h0);
            chk("irq low", {31'h0, o_irq}, 32'h0);
        end
        $display("test requester kinds done");
        u_init.fire(btel_pkg::SRC_USB, 8'h00, 1'b0, 1'b0, 4'ha, 3'h5, 0);
        u_init.fire(btel_pkg::SRC_CPU, 8'h00, 1'b1, 1'b1, 4'h3, 3'h2, 0);
        rd(btel_pkg::OFS_LOG, v);
        chk("repeat log", v, 32'h8300_07a5);
        rd(btel_pkg::OFS_IRQ_STAT, v);
        chk("status both", v, 32'h3);
        rd(btel_pkg::OFS_IRQ_STAT, v);
        chk("status read clear", v, 32'h0);
        wr(btel_pkg::OFS_LOG, 32'h7000_0000);
        rd(btel_pkg::OFS_LOG, v);
        chk("multi kept", v, 32'h8300_07a5);
        wr(btel_pkg::OFS_LOG, 32'h8000_0000);
        rd(btel_pkg::OFS_LOG, v);
        chk("multi cleared", v, 32'h0300_07a5);
        $display("test repeat done");
        wr(btel_pkg::OFS_IRQ_MASK, 32'h0);
        wr(btel_pkg::OFS_LOG, 32'h0f00_0000);
        u_init.fire(btel_pkg::SRC_OTHER, 8'h0e, 1'b0, 1'b0, 4'hf, 3'h7, 1);
        #1 chk("masked irq", {31'h0, o_irq}, 32'h0);
        rd(btel_pkg::OFS_LOG, v);
        chk("top other id", v, 32'h0300_0ef7);
        rd(btel_pkg::OFS_IRQ_STAT, v);
        chk("masked status", v, 32'h1);
        wr(8'h0c, 32'hffff_ffff);
        rd(8'h0c, v);
        chk("unmapped", v, 32'h0);
        wr(btel_pkg::OFS_LOG, 32'h0f00_0000);
        u_init.fire(btel_pkg::SRC_OTHER, 8'h0f, 1'b0, 1'b0, 4'h1, 3'h2, 0);
        rd(btel_pkg::OFS_LOG, v);
        chk("reserved id", v, 32'h0300_0012);
        $display("test mask done");
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        rd(btel_pkg::OFS_LOG, v);
        chk("log after reset", v, 32'h0);
        chk("logged after reset", {31'h0, o_error_logged}, 32'h0);
        rd(btel_pkg::OFS_IRQ_STAT, v);
        chk("status after reset", v, 32'h0);
        chk("irq after reset", {31'h0, o_irq}, 32'h0);
        $display("test mid reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
